// [design/pwmc_pkg.sv]
// Shared constants for the pulse-width modulator channel core
package pwmc_pkg;

  // Bus and channel geometry
  localparam int NUM_CH  = 8;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 8;
  localparam int CH_W    = 3;
  localparam int GRP_W   = ADDR_W - CH_W;
  localparam int PRESC_W = 3;
  localparam int DIV_W   = 7;

  // Control register byte offsets
  localparam logic [ADDR_W-1:0] A_ENABLE   = 8'h00;
  localparam logic [ADDR_W-1:0] A_POLARITY = 8'h01;
  localparam logic [ADDR_W-1:0] A_CENTER   = 8'h02;
  localparam logic [ADDR_W-1:0] A_CLKSEL   = 8'h03;
  localparam logic [ADDR_W-1:0] A_PRESC_A  = 8'h04;
  localparam logic [ADDR_W-1:0] A_PRESC_B  = 8'h05;

  // Per-channel groups: offset = group * 8 + channel
  localparam logic [GRP_W-1:0] GRP_CNT  = 5'h01;
  localparam logic [GRP_W-1:0] GRP_PER  = 5'h02;
  localparam logic [GRP_W-1:0] GRP_DUTY = 5'h03;

  // Reset values and counter constants
  localparam logic [DATA_W-1:0]  RST_BYTE   = 8'h00;
  localparam logic [PRESC_W-1:0] RST_PRESC  = 3'h0;
  localparam logic [DATA_W-1:0]  CNT_ZERO   = 8'h00;
  localparam logic [DATA_W-1:0]  CNT_ONE    = 8'h01;
  localparam logic [DIV_W-1:0]   DIV_ZERO   = 7'h00;
  localparam logic [DIV_W-1:0]   DIV_ONE    = 7'h01;
  localparam logic [DIV_W-1:0]   DIV_ALL    = 7'h7F;

endpackage

// [design/pwmc_presc.sv]
// Power-of-two prescaler producing a one-cycle clock-source tick
`timescale 1ns/1ns
module pwmc_presc (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         nrst,
  // Divider select: tick every 2**div_sel cycles
  input  wire logic [pwmc_pkg::PRESC_W-1:0] div_sel,
  // Source tick
  output logic                              tick
);

  logic [pwmc_pkg::DIV_W-1:0] div_cnt_reg;
  logic [pwmc_pkg::DIV_W-1:0] div_mask;
  logic                       tick_reg;

  // Mask of low counter bits that must all be one
  assign div_mask = ~(pwmc_pkg::DIV_ALL << div_sel);
  assign tick     = tick_reg;

  // Free-running divider and registered tick
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_cnt_reg <= pwmc_pkg::DIV_ZERO;
      tick_reg    <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_reg + pwmc_pkg::DIV_ONE;
      tick_reg    <= ((div_cnt_reg & div_mask) == div_mask);
    end
  end

endmodule // pwmc_presc

// [design/pwmc_core.sv]
// Eight-channel pulse-width modulator core with register port
//
// Contract
// - enable gates channel clock at source edges
// - disabled channel counter holds its value
// - polarity one: start high, low at duty
// - polarity zero: start low, high at duty
// - period and duty double buffered while enabled
// - counter write clears count, loads buffers
// - disabled writes reach buffer and latch together
// - counter value readable at any time
// - duty means high or low time by polarity
// - own 8-bit up/down counter per channel
// - duty match toggles the output flip-flop
// - period match action depends on alignment
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module pwmc_core (
  // Clock and reset
  input  wire logic                                clk_sys,
  input  wire logic                                nrst,
  // Register port
  input  wire logic [pwmc_pkg::ADDR_W-1:0]         reg_addr,
  input  wire logic [pwmc_pkg::DATA_W-1:0]         reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [pwmc_pkg::DATA_W-1:0]         reg_rdata,
  // Channel waveform outputs
  output logic      [pwmc_pkg::NUM_CH-1:0]         pwm_out
);

  // Global control registers
  logic [pwmc_pkg::NUM_CH-1:0]  en_reg;
  logic [pwmc_pkg::NUM_CH-1:0]  pol_reg;
  logic [pwmc_pkg::NUM_CH-1:0]  center_reg;
  logic [pwmc_pkg::NUM_CH-1:0]  clksel_reg;
  logic [pwmc_pkg::PRESC_W-1:0] presc_a_reg;
  logic [pwmc_pkg::PRESC_W-1:0] presc_b_reg;
  logic [pwmc_pkg::DATA_W-1:0]  rdata_reg;

  // Address decode
  logic [pwmc_pkg::GRP_W-1:0]   acc_grp;
  logic [pwmc_pkg::CH_W-1:0]    acc_ch;
  logic                         wr_en;
  logic                         wr_pol;
  logic                         wr_center;
  logic                         wr_clksel;
  logic                         wr_presc_a;
  logic                         wr_presc_b;
  logic                         wr_cnt_any;
  logic                         wr_per_any;
  logic                         wr_duty_any;

  // Clock-source ticks
  logic                         tick_a;
  logic                         tick_b;

  // Per-channel views for the read path and output
  logic [pwmc_pkg::DATA_W-1:0]  cnt_view  [pwmc_pkg::NUM_CH];
  logic [pwmc_pkg::DATA_W-1:0]  per_view  [pwmc_pkg::NUM_CH];
  logic [pwmc_pkg::DATA_W-1:0]  duty_view [pwmc_pkg::NUM_CH];
  logic [pwmc_pkg::NUM_CH-1:0]  lvl_vec;

  // Read selection
  logic [pwmc_pkg::DATA_W-1:0]  rd_ctl;
  logic [pwmc_pkg::DATA_W-1:0]  rd_chan;
  logic [pwmc_pkg::DATA_W-1:0]  rd_mux;
  logic                         rd_is_ctl;

  // Address hits shared by write and read paths
  logic                         hit_en;
  logic                         hit_pol;
  logic                         hit_center;
  logic                         hit_clksel;
  logic                         hit_presc_a;
  logic                         hit_presc_b;
  logic                         hit_cnt;
  logic                         hit_per;
  logic                         hit_duty;
  logic [pwmc_pkg::DATA_W-1:0]  presc_a_view;
  logic [pwmc_pkg::DATA_W-1:0]  presc_b_view;

  // Split address into group and channel index
  assign acc_grp     = reg_addr[pwmc_pkg::ADDR_W-1:pwmc_pkg::CH_W];
  assign acc_ch      = reg_addr[pwmc_pkg::CH_W-1:0];

  // Address hits for control registers
  assign hit_en      = (reg_addr == pwmc_pkg::A_ENABLE);
  assign hit_pol     = (reg_addr == pwmc_pkg::A_POLARITY);
  assign hit_center  = (reg_addr == pwmc_pkg::A_CENTER);
  assign hit_clksel  = (reg_addr == pwmc_pkg::A_CLKSEL);
  assign hit_presc_a = (reg_addr == pwmc_pkg::A_PRESC_A);
  assign hit_presc_b = (reg_addr == pwmc_pkg::A_PRESC_B);

  // Address hits for per-channel groups
  assign hit_cnt     = (acc_grp == pwmc_pkg::GRP_CNT);
  assign hit_per     = (acc_grp == pwmc_pkg::GRP_PER);
  assign hit_duty    = (acc_grp == pwmc_pkg::GRP_DUTY);

  // Write strobes for control registers
  assign wr_en       = reg_wr && hit_en;
  assign wr_pol      = reg_wr && hit_pol;
  assign wr_center   = reg_wr && hit_center;
  assign wr_clksel   = reg_wr && hit_clksel;
  assign wr_presc_a  = reg_wr && hit_presc_a;
  assign wr_presc_b  = reg_wr && hit_presc_b;

  // Write strobes for per-channel groups
  assign wr_cnt_any  = reg_wr && hit_cnt;
  assign wr_per_any  = reg_wr && hit_per;
  assign wr_duty_any = reg_wr && hit_duty;

  // Channel enable bits
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      en_reg <= pwmc_pkg::RST_BYTE;
    end else if (wr_en) begin
      en_reg <= reg_wdata;
    end
  end

  // Polarity bits
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pol_reg <= pwmc_pkg::RST_BYTE;
    end else if (wr_pol) begin
      pol_reg <= reg_wdata;
    end
  end

  // Alignment bits
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      center_reg <= pwmc_pkg::RST_BYTE;
    end else if (wr_center) begin
      center_reg <= reg_wdata;
    end
  end

  // Clock source select bits
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clksel_reg <= pwmc_pkg::RST_BYTE;
    end else if (wr_clksel) begin
      clksel_reg <= reg_wdata;
    end
  end

  // Prescaler A setting
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      presc_a_reg <= pwmc_pkg::RST_PRESC;
    end else if (wr_presc_a) begin
      presc_a_reg <= reg_wdata[pwmc_pkg::PRESC_W-1:0];
    end
  end

  // Prescaler B setting
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      presc_b_reg <= pwmc_pkg::RST_PRESC;
    end else if (wr_presc_b) begin
      presc_b_reg <= reg_wdata[pwmc_pkg::PRESC_W-1:0];
    end
  end

  // Two shared prescaled clock sources
  pwmc_presc u_presc_a (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .div_sel (presc_a_reg),
    .tick    (tick_a)
  );

  pwmc_presc u_presc_b (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .div_sel (presc_b_reg),
    .tick    (tick_b)
  );

  // Channel engines
  for (genvar gi = 0; gi < pwmc_pkg::NUM_CH; gi++) begin : g_ch
    logic [pwmc_pkg::DATA_W-1:0] cnt_reg;
    logic [pwmc_pkg::DATA_W-1:0] per_buf_reg;
    logic [pwmc_pkg::DATA_W-1:0] duty_buf_reg;
    logic [pwmc_pkg::DATA_W-1:0] per_act_reg;
    logic [pwmc_pkg::DATA_W-1:0] duty_act_reg;
    logic                        dir_dn_reg;
    logic                        gate_reg;
    logic                        lvl_reg;
    logic                        sel_me;
    logic                        wr_cnt;
    logic                        wr_per;
    logic                        wr_duty;
    logic                        src_tick;
    logic                        run;
    logic [pwmc_pkg::DATA_W-1:0] per_buf_next;
    logic [pwmc_pkg::DATA_W-1:0] duty_buf_next;
    logic [pwmc_pkg::DATA_W-1:0] cnt_up;
    logic [pwmc_pkg::DATA_W-1:0] cnt_dn;
    logic                        up_hits_per;
    logic                        left_end;
    logic                        ctr_top;
    logic                        ctr_end;
    logic                        period_end;
    logic [pwmc_pkg::DATA_W-1:0] cnt_step;
    logic                        duty_match;
    logic                        reload;
    logic                        start_lvl;

    // Channel select and strobes
    assign sel_me   = (acc_ch == pwmc_pkg::CH_W'(gi));
    assign wr_cnt   = wr_cnt_any && sel_me;
    assign wr_per   = wr_per_any && sel_me;
    assign wr_duty  = wr_duty_any && sel_me;

    // Source clock and gated run condition
    assign src_tick = clksel_reg[gi] ? tick_b : tick_a;
    assign run      = gate_reg && src_tick;

    // Buffer contents after any write this cycle
    assign per_buf_next  = wr_per ? reg_wdata : per_buf_reg;
    assign duty_buf_next = wr_duty ? reg_wdata : duty_buf_reg;

    // Up/down step values
    assign cnt_up      = cnt_reg + pwmc_pkg::CNT_ONE;
    assign cnt_dn      = cnt_reg - pwmc_pkg::CNT_ONE;
    assign up_hits_per = ({1'b0, cnt_reg} + {1'b0, pwmc_pkg::CNT_ONE}) >= {1'b0, per_act_reg};

    // Period match handling per alignment
    assign left_end   = !center_reg[gi] && up_hits_per;
    assign ctr_top    = center_reg[gi] && !dir_dn_reg && up_hits_per;
    assign ctr_end    = center_reg[gi] && dir_dn_reg && (cnt_reg <= pwmc_pkg::CNT_ONE);
    assign period_end = run && (left_end || ctr_end);

    // Next count on a source tick
    assign cnt_step = (left_end || ctr_end) ? pwmc_pkg::CNT_ZERO :
                      (center_reg[gi] && dir_dn_reg) ? cnt_dn : cnt_up;

    // Duty compare on the new count
    assign duty_match = (cnt_step == duty_act_reg);

    // Active latches follow buffers at period end, counter write, or disable
    assign reload = period_end || wr_cnt || !en_reg[gi];

    // Start level by polarity; zero duty flips at once
    assign start_lvl = pol_reg[gi] ^ (duty_buf_next == pwmc_pkg::CNT_ZERO);

    // Buffers and active latches
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        per_buf_reg  <= pwmc_pkg::RST_BYTE;
        duty_buf_reg <= pwmc_pkg::RST_BYTE;
        per_act_reg  <= pwmc_pkg::RST_BYTE;
        duty_act_reg <= pwmc_pkg::RST_BYTE;
      end else begin
        per_buf_reg  <= per_buf_next;
        duty_buf_reg <= duty_buf_next;
        if (reload) begin
          per_act_reg  <= per_buf_next;
          duty_act_reg <= duty_buf_next;
        end
      end
    end

    // Clock gate follows the enable bit only on a source tick
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        gate_reg <= 1'b0;
      end else if (src_tick) begin
        gate_reg <= en_reg[gi];
      end
    end

    // Counter, direction and output flip-flop
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        cnt_reg    <= pwmc_pkg::CNT_ZERO;
        dir_dn_reg <= 1'b0;
        lvl_reg    <= 1'b0;
      end else if (wr_cnt) begin
        cnt_reg    <= pwmc_pkg::CNT_ZERO;
        dir_dn_reg <= 1'b0;
        lvl_reg    <= start_lvl;
      end else if (run) begin
        cnt_reg <= cnt_step;
        if (ctr_top) begin
          dir_dn_reg <= 1'b1;
        end else if (ctr_end || !center_reg[gi]) begin
          dir_dn_reg <= 1'b0;
        end
        if (period_end) begin
          lvl_reg <= start_lvl;
        end else if (duty_match) begin
          lvl_reg <= ~lvl_reg;
        end
      end
    end

    // Views for the read path and output
    assign cnt_view[gi]  = cnt_reg;
    assign per_view[gi]  = per_buf_reg;
    assign duty_view[gi] = duty_buf_reg;
    assign lvl_vec[gi]   = lvl_reg;
  end

  // Prescaler settings widened for the read path
  assign presc_a_view = {{(pwmc_pkg::DATA_W-pwmc_pkg::PRESC_W){1'b0}}, presc_a_reg};
  assign presc_b_view = {{(pwmc_pkg::DATA_W-pwmc_pkg::PRESC_W){1'b0}}, presc_b_reg};

  // Control register read selection
  assign rd_is_ctl = hit_en || hit_pol || hit_center || hit_clksel || hit_presc_a || hit_presc_b;

  assign rd_ctl = hit_en      ? en_reg :
                  hit_pol     ? pol_reg :
                  hit_center  ? center_reg :
                  hit_clksel  ? clksel_reg :
                  hit_presc_a ? presc_a_view :
                  presc_b_view;

  // Per-channel read selection; unmapped reads zero
  assign rd_chan = hit_cnt  ? cnt_view[acc_ch] :
                   hit_per  ? per_view[acc_ch] :
                   hit_duty ? duty_view[acc_ch] :
                   pwmc_pkg::RST_BYTE;

  assign rd_mux = rd_is_ctl ? rd_ctl : rd_chan;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= pwmc_pkg::RST_BYTE;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : pwmc_pkg::RST_BYTE;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_reg;
  assign pwm_out   = lvl_vec;

endmodule // pwmc_core

// [tb/pwmc_checker.sv]
// Assertions on the register port and waveform outputs of the core
`timescale 1ns/1ns
module pwmc_checker (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Waveform outputs
  input wire logic [7:0] pwm_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [7:0] ever_reg, out_reg, hold_reg, cq_reg;
  // Address decode and enable history
  wire       cnt_wr   = reg_wr && reg_addr[7:3] == pwmc_pkg::GRP_CNT;
  wire [7:0] cnt_dec  = cnt_wr ? (8'h01 << reg_addr[2:0]) : 8'h00;
  wire       en_wr    = reg_wr && reg_addr == pwmc_pkg::A_ENABLE;
  wire [7:0] ever_nxt = ever_reg | (en_wr ? reg_wdata : 8'h00);
  wire       rw_addr  = reg_addr < 8'h04 || reg_addr[7:4] == 4'h1;
  wire       bad_addr = reg_addr[7:5] != 3'h0 || reg_addr[7:1] == 7'h03;
  wire       idle_rd  = reg_rd && reg_addr[7:3] == pwmc_pkg::GRP_CNT && !ever_reg[reg_addr[2:0]];
  // Channels never enabled and not just cleared must hold their output
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ever_reg <= 8'h00;
      out_reg  <= 8'h00;
      hold_reg <= 8'h00;
      cq_reg   <= 8'h00;
    end else begin
      ever_reg <= ever_nxt;
      out_reg  <= pwm_out;
      hold_reg <= ~ever_nxt & ~cnt_dec & ~cq_reg;
      cq_reg   <= cnt_dec;
    end
  end
  // Write followed at once by a read of the same place
  sequence s_buf_wr_rd;
    reg_wr && rw_addr ##1 reg_rd && reg_addr == $past(reg_addr);
  endsequence
  sequence s_presc_wr_rd;
    reg_wr && reg_addr[7:1] == 7'h02 ##1 reg_rd && reg_addr == $past(reg_addr);
  endsequence
  sequence s_cnt_wr_rd;
    cnt_wr ##1 reg_rd && reg_addr == $past(reg_addr);
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |-> pwm_out == 8'h00 && reg_rdata == 8'h00)
    else $error("outputs not quiet in reset");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (reg_rd && bad_addr |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_buffer_readback: assert property (s_buf_wr_rd |=> reg_rdata == $past(reg_wdata, 2))
    else $error("buffer readback wrong");
  a_presc_readback: assert property (s_presc_wr_rd |=> reg_rdata == {5'h00, $past(reg_wdata[2:0], 2)})
    else $error("prescaler readback wrong");
  a_count_cleared: assert property (s_cnt_wr_rd |=> reg_rdata == 8'h00)
    else $error("counter not cleared by write");
  a_idle_count: assert property (idle_rd |=> reg_rdata == 8'h00)
    else $error("disabled counter advanced");
  a_idle_hold: assert property (((pwm_out ^ out_reg) & hold_reg) == 8'h00)
    else $error("disabled output moved");
endmodule // pwmc_checker

bind pwmc_core pwmc_checker u_chk (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_out(pwm_out));

// [tb/pwmc_tb.sv]
// Random self-checking testbench for the modulator core
`timescale 1ns/1ns
module testbench;
  logic       clk_sys = 1'b0;
  logic       nrst    = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata, pwm_out, rv, r2, p, d, a;
  logic [2:0] ch;
  logic [31:0] r;
  logic       pv;
  int         fail_count = 0;
  int         total_checks = 0;
  int         seed = 32'hbcd113d2;
  // Clock
  always #5 clk_sys = ~clk_sys;
  pwmc_core dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_out(pwm_out));
  // Comparison, bus cycles and expectations
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= ad;
    reg_wdata <= dt;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
    bus(1'b0, ad, 8'h00);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 dt = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    bus(1'b1, ad, dt);
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  function automatic int exp_high(int pp, int dd, int pl, int c, int s);
    int t;
    t = c ? 2 * dd : dd;
    if (pl == 0) t = (c ? 2 * pp : pp) - t;
    return 2 * t * (s + 1);
  endfunction
  task automatic measure(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1 h += (pwm_out[ch] === 1'b1);
    end
  endtask
  // One channel set up while disabled, then run and measured
  task automatic run(input int pl, input int c, input int s);
    int n;
    int h;
    n = p * (c + 1) * (s + 1);
    wr(pwmc_pkg::A_ENABLE, 8'h00);
    wr(pwmc_pkg::A_PRESC_A, 8'h00);
    wr(pwmc_pkg::A_PRESC_B, 8'h01);
    wr({pwmc_pkg::GRP_PER, ch}, p);
    wr({pwmc_pkg::GRP_DUTY, ch}, d);
    wr(pwmc_pkg::A_POLARITY, pl ? 8'h01 << ch : 8'h00);
    wr(pwmc_pkg::A_CENTER, c ? 8'h01 << ch : 8'h00);
    wr(pwmc_pkg::A_CLKSEL, s ? 8'h01 << ch : 8'h00);
    // Clear count and direction left over from an earlier run
    wr({pwmc_pkg::GRP_CNT, ch}, 8'h00);
    wr(pwmc_pkg::A_ENABLE, 8'h01 << ch);
    rd(pwmc_pkg::A_ENABLE, rv);
    check(rv, 8'h01 << ch);
    repeat (n + 4) @(posedge clk_sys);
    measure(2 * n, h);
    check(h, exp_high(p, d, pl, c, s));
    rd({pwmc_pkg::GRP_CNT, ch}, rv);
    check(rv <= p, 1'b1);
    d = (d <= 8'h01) ? 8'h02 : d - 8'h01;
    wr({pwmc_pkg::GRP_DUTY, ch}, d);
    bus(1'b1, {pwmc_pkg::GRP_CNT, ch}, r[7:0]);
    rd({pwmc_pkg::GRP_CNT, ch}, rv);
    check(rv, 8'h00);
    repeat (n + 2) @(posedge clk_sys);
    measure(2 * n, h);
    check(h, exp_high(p, d, pl, c, s));
    wr(pwmc_pkg::A_ENABLE, 8'h00);
    repeat (8) @(posedge clk_sys);
    rd({pwmc_pkg::GRP_CNT, ch}, rv);
    pv = pwm_out[ch];
    repeat (20) @(posedge clk_sys);
    rd({pwmc_pkg::GRP_CNT, ch}, r2);
    check(r2, rv);
    check(pwm_out[ch], pv);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (40000) @(posedge clk_sys);
    fail_count++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    check(pwm_out, 8'h00);
    for (int i = 0; i < 40; i++) begin
      rd(i[7:0], rv);
      check(rv, 8'h00);
    end
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      a = r[4] ? {4'h1, r[3:0]} : {6'h00, r[1:0]} + 8'h01 + {7'h00, r[5]};
      a = (i == 0) ? 8'h06 : a;
      bus(1'b1, a, r[15:8]);
      rd(a, rv);
      check(rv, a == 8'h06 ? 8'h00 : (a[7:1] == 7'h02 ? r[15:8] & 8'h07 : r[15:8]));
    end
    ch = 3'h0;
    p = 8'h04;
    d = 8'h02;
    run(1, 0, 0);
    ch = 3'h5;
    p = 8'h06;
    d = 8'h00;
    run(1, 0, 0);
    ch = 3'h7;
    p = 8'h05;
    d = 8'h05;
    run(0, 0, 1);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      ch = r[2:0];
      p = 8'h03 + {4'h0, r[6:3]};
      d = 8'h01 + r[15:8] % (p - 8'h01);
      run(r[16], r[17], r[18]);
    end
    final_report();
  end
endmodule // testbench
